// ===== logic/t2ud_pkg.sv
// Purpose: constants and carrier types for the timer 2 extended-mode block
// Assumes: one clk_sys period is a quarter of an oscillator period
// Notes: registers are word addresses on an AHB-Lite slave
package t2ud_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_CLK_CTRL = 8'h8E;
  localparam logic [7:0] IDX_CLK_MODE = 8'h96;
  localparam logic [7:0] IDX_T2_CTRL = 8'hC8;
  localparam logic [7:0] IDX_T2_MODE = 8'hC9;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] IDX_COUNT_LOW = 8'hCC;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] IDX_POWER_MODE = 8'hC4;
  localparam logic [7:0] IDX_SERIAL_MODE = 8'h98;
  // timer control, mode, clock and power register bit positions
  localparam int CTL_OVF = 7;
  localparam int CTL_EXF = 6;
  localparam int CTL_RCLK = 5;
  localparam int CTL_TX_CLOCK_SELECT = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CT = 1;
  localparam int CTL_CPRL = 0;
  localparam int MOD_UPDOWN = 0;
  localparam int MOD_CLKOUT = 1;
  localparam int CKC_SLOW_T2 = 5;
  localparam int CKM_FAST_T2 = 5;
  localparam int PMR_CD_HI = 7;
  localparam int PMR_CD_LO = 6;
  localparam int PMR_X4 = 3;
  // reset values and the all-ones count
  localparam logic [7:0] RST_CLK_CTRL = 8'h01;
  localparam logic [7:0] RST_CLK_MODE = 8'h00;
  localparam logic [7:0] RST_POWER_MODE = 8'h40;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  // divider figures in ticks of the 4x time grid (quarter oscillator periods)
  localparam int DIV_STD = 48;
  localparam int DIV_BAUD = 8;
  localparam int DIV_BAUD_PM = 8192;
  localparam int DIV_PM_STD = 12288;
  localparam int DIV_PM_FAST = 4096;
  localparam int DIV_ONE = 4;
  localparam int DIV_FAST_4X = 1;
  localparam int DIV_FAST_2X = 2;
  localparam int DIV_SLOW_4X = 4;
  localparam int DIV_SLOW_2X = 8;
  localparam int DIV_SLOW_1X = 16;
  // system clock modes
  typedef enum logic [1:0] {T2UD_X4 = 2'b00, T2UD_X2 = 2'b01, T2UD_X1 = 2'b11,
    T2UD_PM = 2'b10} t2ud_sysmode_t;
  // bus address phase, addr holds the register index
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } t2ud_aphase_t;
endpackage : t2ud_pkg

// ===== logic/t2ud_timer2.sv
// Purpose: timer 2 up/down, baud-rate and clock-out modes with prescale select
// Assumes: one clk_sys at four times the oscillator; pins synchronous
// Notes: no interrupt logic; flags are visible in the control register
// Overview of operation
// - updown bit enables pin-directed counting
// - up overflow loads reload pair, or zero in capture mode
// - down match with reload loads FFFFh
// - updown overflow/underflow sets overflow flag
// - updown wraps toggle external flag
// - clock selects force 16-bit autoreload
// - baud overflow reloads, shift clock, no flag
// - baud mode pin fall sets external flag
// - baud/clockout time base oscillator over two
// - power mode baud base oscillator over 2048
// - counter select uses count pin edges
// - reload registers locked while running
// - clockout mode toggles count pin on overflow
// - clockout overflow raises no flag
// - clockout and serial share overflows
// - reset defaults to oscillator over twelve
// - fast prescale overrides slow prescale
// - divider table per system clock mode
// - plain autoreload pin fall forces reload
module t2ud_timer2 #(
  parameter int DIV_W = 14
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [9:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic t2_ext_pin,
  input wire logic count_pin_in,
  output logic count_pin_out,
  output logic count_pin_oe_n,
  output logic shift_clock
);
  // registers
  logic [7:0] ctrl_reg, ctrl_next, mod_reg, mod_next, ckc_reg, ckc_next, ckm_reg, ckm_next;
  logic [7:0] pmr_reg, pmr_next, smod_reg, smod_next;
  logic [15:0] reload_reg, reload_next, count_reg, count_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [1:0] ext_sync_reg, ext_sync_next, cnt_sync_reg, cnt_sync_next;
  logic ext_last_reg, ext_last_next, cnt_last_reg, cnt_last_next;
  logic pin_reg, pin_next, oe_n_reg, oe_n_next, shift_reg, shift_next;
  logic [31:0] rdata_reg, rdata_next;
  t2ud_pkg::t2ud_aphase_t ap_reg, ap_next;
  // decode helpers
  logic baud_mode, clkout_mode, reload_mode, updown, tick, ext_fall, cnt_fall;
  logic wrap_up, wrap_dn, wrap, count_en;
  logic [DIV_W-1:0] div_limit;
  t2ud_pkg::t2ud_sysmode_t sysmode;

  // system clock mode from power register bits
  function automatic t2ud_pkg::t2ud_sysmode_t sysmode_of(input logic [7:0] p);
    if (p[t2ud_pkg::PMR_CD_HI] && p[t2ud_pkg::PMR_CD_LO])
      return t2ud_pkg::T2UD_PM;
    else if (!p[t2ud_pkg::PMR_CD_HI] && !p[t2ud_pkg::PMR_CD_LO])
      return p[t2ud_pkg::PMR_X4] ? t2ud_pkg::T2UD_X4 : t2ud_pkg::T2UD_X2;
    else
      return t2ud_pkg::T2UD_X1;
  endfunction : sysmode_of

  // read mux, used for bus reads
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] c,
    input logic [7:0] m, input logic [15:0] rl, input logic [15:0] cn,
    input logic [7:0] k, input logic [7:0] km, input logic [7:0] p, input logic [7:0] s);
    case (a)
      t2ud_pkg::IDX_T2_CTRL: return c;
      t2ud_pkg::IDX_T2_MODE: return m;
      t2ud_pkg::IDX_RELOAD_LOW: return rl[7:0];
      t2ud_pkg::IDX_RELOAD_HIGH: return rl[15:8];
      t2ud_pkg::IDX_COUNT_LOW: return cn[7:0];
      t2ud_pkg::IDX_COUNT_HIGH: return cn[15:8];
      t2ud_pkg::IDX_CLK_CTRL: return k;
      t2ud_pkg::IDX_CLK_MODE: return km;
      t2ud_pkg::IDX_POWER_MODE: return p;
      t2ud_pkg::IDX_SERIAL_MODE: return s;
      default: return 8'h00;
    endcase
  endfunction : reg_read

  // mode decode
  always_comb
  begin
    sysmode = sysmode_of(pmr_reg);
    baud_mode = ctrl_reg[t2ud_pkg::CTL_RCLK] | ctrl_reg[t2ud_pkg::CTL_TX_CLOCK_SELECT];
    reload_mode = baud_mode | ~ctrl_reg[t2ud_pkg::CTL_CPRL];
    // clockout needs autoreload timer; forced reload counts too
    clkout_mode = mod_reg[t2ud_pkg::MOD_CLKOUT] & reload_mode & ~ctrl_reg[t2ud_pkg::CTL_CT];
    // up/down only outside baud and clockout
    updown = mod_reg[t2ud_pkg::MOD_UPDOWN] & reload_mode & ~baud_mode & ~clkout_mode;
  end

  // input clock divider limit
  always_comb
  begin
    div_limit = DIV_W'(t2ud_pkg::DIV_STD);
    if (baud_mode || clkout_mode)
    begin
      if (sysmode == t2ud_pkg::T2UD_PM)
        div_limit = DIV_W'(t2ud_pkg::DIV_BAUD_PM);
      else
        div_limit = DIV_W'(t2ud_pkg::DIV_BAUD);
    end
    else
    begin
      case (sysmode)
        t2ud_pkg::T2UD_PM:
          div_limit = (ckm_reg[t2ud_pkg::CKM_FAST_T2] || ckc_reg[t2ud_pkg::CKC_SLOW_T2]) ?
            DIV_W'(t2ud_pkg::DIV_PM_FAST) : DIV_W'(t2ud_pkg::DIV_PM_STD);
        t2ud_pkg::T2UD_X4:
          div_limit = ckm_reg[t2ud_pkg::CKM_FAST_T2] ? DIV_W'(t2ud_pkg::DIV_FAST_4X) :
            ckc_reg[t2ud_pkg::CKC_SLOW_T2] ? DIV_W'(t2ud_pkg::DIV_SLOW_4X) :
            DIV_W'(t2ud_pkg::DIV_STD);
        t2ud_pkg::T2UD_X2:
          div_limit = ckm_reg[t2ud_pkg::CKM_FAST_T2] ? DIV_W'(t2ud_pkg::DIV_FAST_2X) :
            ckc_reg[t2ud_pkg::CKC_SLOW_T2] ? DIV_W'(t2ud_pkg::DIV_SLOW_2X) :
            DIV_W'(t2ud_pkg::DIV_STD);
        t2ud_pkg::T2UD_X1:
          div_limit = ckm_reg[t2ud_pkg::CKM_FAST_T2] ? DIV_W'(t2ud_pkg::DIV_ONE) :
            ckc_reg[t2ud_pkg::CKC_SLOW_T2] ? DIV_W'(t2ud_pkg::DIV_SLOW_1X) :
            DIV_W'(t2ud_pkg::DIV_STD);
        default: div_limit = DIV_W'(t2ud_pkg::DIV_STD);
      endcase
    end
  end

  // divider in quarter-oscillator steps; one clk_sys is one step
  always_comb
  begin
    div_next = div_reg;
    tick = 1'b0;
    if (!ctrl_reg[t2ud_pkg::CTL_RUN])
      div_next = '0;
    else if (DIV_W'(div_reg + DIV_W'(1)) >= div_limit)
    begin
      tick = 1'b1;
      div_next = '0;
    end
    else
      div_next = DIV_W'(div_reg + DIV_W'(1));
  end

  always_comb
  begin
    ext_sync_next = {ext_sync_reg[0], t2_ext_pin};
    cnt_sync_next = {cnt_sync_reg[0], count_pin_in};
    ext_last_next = ext_sync_reg[1];
    cnt_last_next = cnt_sync_reg[1];
    ext_fall = ext_last_reg & ~ext_sync_reg[1];
    cnt_fall = cnt_last_reg & ~cnt_sync_reg[1];
  end

  // counter, flags and output pin
  always_comb
  begin
    count_next = count_reg;
    pin_next = pin_reg;
    shift_next = 1'b0;
    oe_n_next = ~clkout_mode;
    // counter mode counts pin falls, no prescale
    count_en = ctrl_reg[t2ud_pkg::CTL_RUN] & (ctrl_reg[t2ud_pkg::CTL_CT] ? cnt_fall : tick);
    wrap_up = count_en & (~updown | ext_sync_reg[1]) & (count_reg == t2ud_pkg::CNT_ALL_ONES);
    wrap_dn = count_en & updown & ~ext_sync_reg[1] & (count_reg == reload_reg);
    wrap = wrap_up | wrap_dn;
    if (count_en)
    begin
      if (wrap_dn)
        count_next = t2ud_pkg::CNT_ALL_ONES;
      else if (wrap_up)
        count_next = reload_mode ? reload_reg : 16'h0000;
      else if (updown && !ext_sync_reg[1])
        count_next = 16'(count_reg - 16'h0001);
      else
        count_next = 16'(count_reg + 16'h0001);
    end
    if (ctrl_reg[t2ud_pkg::CTL_EXEN] && ext_fall && reload_mode && !updown && !baud_mode)
      count_next = reload_reg;
    shift_next = wrap_up & baud_mode;
    if (clkout_mode && wrap_up)
      pin_next = ~pin_reg;
    else if (!clkout_mode)
      pin_next = 1'b1;
  end

  // registers and bus writes; hardware set wins over software clear
  always_comb
  begin
    logic wr;
    logic [7:0] wd;
    wr = ap_reg.valid & ap_reg.write;
    wd = hwdata[7:0];
    ctrl_next = ctrl_reg;
    mod_next = mod_reg;
    ckc_next = ckc_reg;
    ckm_next = ckm_reg;
    pmr_next = pmr_reg;
    smod_next = smod_reg;
    reload_next = reload_reg;
    if (wr)
    begin
      case (ap_reg.addr)
        t2ud_pkg::IDX_T2_CTRL: ctrl_next = wd;
        t2ud_pkg::IDX_T2_MODE: mod_next = {6'h00, wd[1:0]};
        t2ud_pkg::IDX_CLK_CTRL: ckc_next = wd;
        t2ud_pkg::IDX_CLK_MODE: ckm_next = wd;
        t2ud_pkg::IDX_POWER_MODE: pmr_next = wd;
        t2ud_pkg::IDX_SERIAL_MODE: smod_next = wd;
        t2ud_pkg::IDX_RELOAD_LOW:
          if (!ctrl_reg[t2ud_pkg::CTL_RUN]) reload_next[7:0] = wd;
        t2ud_pkg::IDX_RELOAD_HIGH:
          if (!ctrl_reg[t2ud_pkg::CTL_RUN]) reload_next[15:8] = wd;
        default: ;
      endcase
    end
    // flag not set in baud or clockout
    if ((wrap && updown) || (wrap_up && !baud_mode && !clkout_mode))
      ctrl_next[t2ud_pkg::CTL_OVF] = 1'b1;
    if (wrap && updown)
      ctrl_next[t2ud_pkg::CTL_EXF] = ~ctrl_reg[t2ud_pkg::CTL_EXF];
    else if (ctrl_reg[t2ud_pkg::CTL_EXEN] && ext_fall && !updown)
      ctrl_next[t2ud_pkg::CTL_EXF] = 1'b1;
  end

  // count register writes overlay the counter path
  logic [15:0] count_final;
  always_comb
  begin
    count_final = count_next;
    if (ap_reg.valid && ap_reg.write && ap_reg.addr == t2ud_pkg::IDX_COUNT_LOW)
      count_final[7:0] = hwdata[7:0];
    if (ap_reg.valid && ap_reg.write && ap_reg.addr == t2ud_pkg::IDX_COUNT_HIGH)
      count_final[15:8] = hwdata[7:0];
  end

  // bus address phase capture and read data
  always_comb
  begin
    // byte address is four times the index; unaligned words are ignored
    ap_next.valid = hsel & hready & htrans[1] & (haddr[1:0] == 2'b00);
    ap_next.write = hwrite;
    ap_next.addr = haddr[9:2];
    rdata_next = '0;
    if (hsel && hready && htrans[1] && !hwrite && haddr[1:0] == 2'b00)
      rdata_next = {24'h000000, reg_read(haddr[9:2], ctrl_reg, mod_reg, reload_reg, count_reg,
        ckc_reg, ckm_reg, pmr_reg, smod_reg)};
  end

  // state registers
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_reg <= 8'h00;
      mod_reg <= 8'h00;
      ckc_reg <= t2ud_pkg::RST_CLK_CTRL;
      ckm_reg <= t2ud_pkg::RST_CLK_MODE;
      pmr_reg <= t2ud_pkg::RST_POWER_MODE;
      smod_reg <= 8'h00;
      reload_reg <= 16'h0000;
      count_reg <= 16'h0000;
      div_reg <= '0;
      ext_sync_reg <= 2'h3;
      cnt_sync_reg <= 2'h3;
      ext_last_reg <= 1'b1;
      cnt_last_reg <= 1'b1;
      pin_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      shift_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ap_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      mod_reg <= mod_next;
      ckc_reg <= ckc_next;
      ckm_reg <= ckm_next;
      pmr_reg <= pmr_next;
      smod_reg <= smod_next;
      reload_reg <= reload_next;
      count_reg <= count_final;
      div_reg <= div_next;
      ext_sync_reg <= ext_sync_next;
      cnt_sync_reg <= cnt_sync_next;
      ext_last_reg <= ext_last_next;
      cnt_last_reg <= cnt_last_next;
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
      shift_reg <= shift_next;
      rdata_reg <= rdata_next;
      ap_reg <= ap_next;
    end
  end

  // outputs straight from flops, ready and response tied constant; slave never waits
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign count_pin_out = pin_reg;
  assign count_pin_oe_n = oe_n_reg;
  assign shift_clock = shift_reg;
endmodule : t2ud_timer2

// ===== test/t2ud_checker.sv
// Purpose: port checker for the timer 2 extended-mode block
// Assumes: one clk_sys domain, srst synchronous active high
// Notes: bound to t2ud_timer2 at the foot of this file
module t2ud_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic count_pin_out,
  input wire logic count_pin_oe_n,
  input wire logic shift_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_reg;
  logic rd_next;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // read address phase, so data may only show in the following cycle
  always_comb rd_next = hsel && hready && htrans[1] && !hwrite;
  always_ff @(posedge clk_sys) rd_reg <= rd_next;
  // overflow events never closer than a quarter of the clock
  sequence s_pin_hold;
    ($stable(count_pin_out) || count_pin_oe_n) [*3];
  endsequence
  sequence s_shift_gap;
    !shift_clock [*3];
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_rdata_idle: assert property (!rd_reg |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_rdata_upper: assert property (rd_reg |-> hrdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  a_reset_outs: assert property (@(posedge clk_sys) disable iff (1'b0)
    srst |=> (hrdata == 32'h0 && count_pin_out && count_pin_oe_n && !shift_clock))
    else $error("outputs not at reset level");
  a_pin_idle_high: assert property (count_pin_oe_n |-> count_pin_out)
    else $error("pin level low while released");
  a_pin_gap: assert property (!count_pin_oe_n && $changed(count_pin_out) |=> s_pin_hold)
    else $error("clock-out toggles too close");
  a_shift_gap: assert property (shift_clock |=> s_shift_gap)
    else $error("shift pulses too close");
endmodule : t2ud_checker

bind t2ud_timer2 t2ud_checker u_chk (.clk_sys(clk_sys), .srst(srst), .htrans(htrans),
  .hwrite(hwrite), .hsel(hsel), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .count_pin_out(count_pin_out), .count_pin_oe_n(count_pin_oe_n),
  .shift_clock(shift_clock));

// ===== test/t2ud_far_side.sv
// Purpose: far-side model: edge input, count source, shift clock and pin watch
// Assumes: the count pin wire is resolved from the block's active-low enable
// Notes: tallies only grow, the bench works on differences
module t2ud_far_side (
  input wire logic clk_sys,
  input wire logic dir_level,
  input wire logic src_en,
  input wire logic shift_clock,
  input wire logic count_pin_out,
  input wire logic count_pin_oe_n,
  output logic t2_ext_pin,
  output logic count_pin_in,
  output int shift_cnt,
  output int toggle_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_reg = 4'h0;
  logic pin_reg = 1'b1;
  // source period of 16 clocks, well under a quarter rate
  assign count_pin_in = count_pin_oe_n ? (src_en ? div_reg[3] : 1'b1) : count_pin_out;
  // level driven straight from the bench's dir_level, no pull when idle
  assign t2_ext_pin = dir_level;
  initial
  begin
    shift_cnt = 0;
    toggle_cnt = 0;
  end
  // source divider plus shift pulse and pin edge tallies
  always @(posedge clk_sys)
  begin
    div_reg <= div_reg + 4'h1;
    pin_reg <= count_pin_out;
    if (shift_clock === 1'b1)
      shift_cnt <= shift_cnt + 1;
    if (count_pin_oe_n === 1'b0 && count_pin_out !== pin_reg)
      toggle_cnt <= toggle_cnt + 1;
  end
endmodule : t2ud_far_side

// ===== test/t2ud_timer2_tb.sv
// Purpose: self-checking bench for the timer 2 extended-mode block
// Assumes: zero-wait AHB-Lite slave, one word per register
// Notes: rates are judged as tick counts over fixed spans
module t2ud_timer2_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [9:0] haddr = 10'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic dir_level = 1'b0;
  logic src_en = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, t2_ext_pin, count_pin_in, count_pin_out, count_pin_oe_n, shift_clock;
  logic [7:0] v;
  int shift_cnt, toggle_cnt;
  int error_cnt = 0;
  int n_tests = 0;
  t2ud_timer2 DUT (.clk_sys(clk_sys), .srst(srst), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hsel(hsel), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .t2_ext_pin(t2_ext_pin),
    .count_pin_in(count_pin_in), .count_pin_out(count_pin_out),
    .count_pin_oe_n(count_pin_oe_n), .shift_clock(shift_clock));
  t2ud_far_side u_far (.clk_sys(clk_sys), .dir_level(dir_level), .src_en(src_en),
    .shift_clock(shift_clock), .count_pin_out(count_pin_out), .count_pin_oe_n(count_pin_oe_n),
    .t2_ext_pin(t2_ext_pin), .count_pin_in(count_pin_in), .shift_cnt(shift_cnt),
    .toggle_cnt(toggle_cnt));
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single transfer; read byte lands in v at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {a, 2'b00};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    v = hrdata[7:0];
  endtask : bus
  task automatic setup(input logic [7:0] ckc, ckm, power_mode_register, md, input logic [15:0] rl, cn);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h00);
    bus(1'b1, t2ud_pkg::IDX_CLK_CTRL, ckc);
    bus(1'b1, t2ud_pkg::IDX_CLK_MODE, ckm);
    bus(1'b1, t2ud_pkg::IDX_POWER_MODE, power_mode_register);
    bus(1'b1, t2ud_pkg::IDX_T2_MODE, md);
    bus(1'b1, t2ud_pkg::IDX_RELOAD_LOW, rl[7:0]);
    bus(1'b1, t2ud_pkg::IDX_RELOAD_HIGH, rl[15:8]);
    bus(1'b1, t2ud_pkg::IDX_COUNT_LOW, cn[7:0]);
    bus(1'b1, t2ud_pkg::IDX_COUNT_HIGH, cn[15:8]);
  endtask : setup
  task automatic wait_flag;
    v = 8'h00;
    for (int i = 0; i < 50 && v[7] !== 1'b1; i++)
      bus(1'b0, t2ud_pkg::IDX_T2_CTRL, 8'h00);
  endtask : wait_flag
  task automatic t_reset;
    bus(1'b0, t2ud_pkg::IDX_CLK_CTRL, 8'h00);
    chk(v, t2ud_pkg::RST_CLK_CTRL);
    bus(1'b0, t2ud_pkg::IDX_CLK_MODE, 8'h00);
    chk(v, t2ud_pkg::RST_CLK_MODE);
    bus(1'b0, 8'h00, 8'h00);
    chk(v, 8'h00);
  endtask : t_reset
  // rows: clk ctrl, clk mode, power mode, t2 ctrl
  task automatic t_rates;
    logic [31:0] cfg [8] = '{32'h01004004, 32'h21004004, 32'h21204004, 32'h01200804,
      32'h01200004, 32'h0120C004, 32'h21204014, 32'h0100C014};
    int k [8] = '{10, 20, 20, 40, 40, 3, 20, 3};
    int dv [8] = '{48, 16, 4, 1, 2, 4096, 8, 8192};
    dir_level <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      setup(cfg[i][31:24], cfg[i][23:16], cfg[i][15:8], 8'h00, 16'h0000, 16'h0000);
      bus(1'b1, t2ud_pkg::IDX_T2_CTRL, cfg[i][7:0]);
      repeat (k[i] * dv[i]) @(posedge clk_sys);
      bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h00);
      bus(1'b0, t2ud_pkg::IDX_COUNT_LOW, 8'h00);
      chk(v >= k[i] - 1 && v <= k[i] + 2, 1'b1);
    end
  endtask : t_rates
  task automatic t_updown;
    dir_level <= 1'b1;
    setup(8'h01, 8'h20, 8'h40, 8'h01, 16'h1234, 16'hFFFC);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h04);
    wait_flag();
    chk(v, 8'hC4);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h00);
    bus(1'b0, t2ud_pkg::IDX_COUNT_HIGH, 8'h00);
    chk(v, 8'h12);
    dir_level <= 1'b0;
    bus(1'b1, t2ud_pkg::IDX_COUNT_LOW, 8'h36);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h04);
    wait_flag();
    chk(v, 8'hC4);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h00);
    bus(1'b0, t2ud_pkg::IDX_COUNT_HIGH, 8'h00);
    chk(v, 8'hFF);
  endtask : t_updown
  task automatic t_baud_out;
    int s0, p0;
    dir_level <= 1'b1;
    setup(8'h01, 8'h00, 8'h40, 8'h02, 16'hFFFE, 16'hFFFE);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h1D);
    s0 = shift_cnt;
    p0 = toggle_cnt;
    repeat (320) @(posedge clk_sys);
    chk(shift_cnt - s0 inside {[19:21]}, 1'b1);
    chk(toggle_cnt - p0 inside {[19:21]}, 1'b1);
    chk(count_pin_oe_n, 1'b0);
    bus(1'b1, t2ud_pkg::IDX_RELOAD_LOW, 8'h00);
    bus(1'b0, t2ud_pkg::IDX_RELOAD_LOW, 8'h00);
    chk(v, 8'hFE);
    dir_level <= 1'b0;
    repeat (8) @(posedge clk_sys);
    bus(1'b0, t2ud_pkg::IDX_T2_CTRL, 8'h00);
    chk(v & 8'hC0, 8'h40);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h00);
    bus(1'b1, t2ud_pkg::IDX_RELOAD_LOW, 8'h55);
    bus(1'b0, t2ud_pkg::IDX_RELOAD_LOW, 8'h00);
    chk(v, 8'h55);
  endtask : t_baud_out
  // external source at half the internal rate
  task automatic t_ext_count;
    int s0;
    setup(8'h01, 8'h00, 8'h40, 8'h00, 16'hFFFE, 16'hFFFE);
    src_en <= 1'b1;
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h16);
    s0 = shift_cnt;
    repeat (320) @(posedge clk_sys);
    chk(shift_cnt - s0 inside {[9:11]}, 1'b1);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h00);
    src_en <= 1'b0;
  endtask : t_ext_count
  // pin fall forces a reload in plain autoreload, stopped timer
  task automatic t_pin_reload;
    dir_level <= 1'b1;
    setup(8'h01, 8'h00, 8'h40, 8'h00, 16'h1234, 16'h0000);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h08);
    dir_level <= 1'b0;
    repeat (8) @(posedge clk_sys);
    bus(1'b0, t2ud_pkg::IDX_COUNT_HIGH, 8'h00);
    chk(v, 8'h12);
    bus(1'b0, t2ud_pkg::IDX_T2_CTRL, 8'h00);
    chk(v, 8'h48);
    bus(1'b1, t2ud_pkg::IDX_T2_CTRL, 8'h00);
  endtask : t_pin_reload
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // main sequence: reset for four cycles, then each scenario
  initial
  begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_rates();
    t_updown();
    t_baud_out();
    t_ext_count();
    t_pin_reload();
    end_sim();
  end
  // watchdog: the run needs about 39k cycles
  initial
  begin
    #400000;
    error_cnt++;
    end_sim();
  end
endmodule : t2ud_timer2_tb
